/* File: include/itd_pkg.sv */
// Shared types and constants of the instruction timing decoder.
// Assumes 14-bit words from program memory on the core clock.
package itd_pkg;

    // Word layout
    localparam int unsigned INSTR_W      = 14;
    localparam int unsigned FILE_ADDR_W  = 7;
    localparam int unsigned BIT_POS_W    = 3;
    localparam int unsigned LITERAL_W    = 8;
    localparam int unsigned CYCLE_CNT_W  = 2;
    localparam int unsigned PTR_COUNT    = 2;

    // Field positions
    localparam int unsigned FILE_LSB     = 0;
    localparam int unsigned BIT_POS_LSB  = 7;
    localparam int unsigned DEST_POS     = 7;
    localparam int unsigned MODE_LSB     = 0;
    localparam int unsigned PTR_MM_POS   = 2;
    localparam int unsigned PTR_K_POS    = 6;

    // Timing
    localparam int unsigned OSC_PER_INSTR = 4;
    localparam logic [1:0]  PHASE_RESET   = 2'h0;
    localparam logic [CYCLE_CNT_W-1:0] CYCLES_BASE   = 2'h1;
    localparam logic [CYCLE_CNT_W-1:0] CYCLES_ADDED  = 2'h1;

    // Destination select
    localparam logic DEST_ACC     = 1'b0;
    localparam logic DEST_FILE    = 1'b1;
    localparam logic DEST_DEFAULT = DEST_FILE;

    // Indirect access ports sit at file addresses 0 and 1
    localparam logic [FILE_ADDR_W-1:0] ACCESS_PORT_MASK = 7'h7e;
    localparam logic [FILE_ADDR_W-1:0] ACCESS_PORT_BASE = 7'h00;

    // Opcode masks and values
    localparam logic [INSTR_W-1:0] MSK_TOP2       = 14'h3000;
    localparam logic [INSTR_W-1:0] VAL_BYTE       = 14'h0000;
    localparam logic [INSTR_W-1:0] VAL_BIT        = 14'h1000;
    localparam logic [INSTR_W-1:0] MSK_CTRL_LOW   = 14'h3f80;
    localparam logic [INSTR_W-1:0] VAL_CTRL_LOW   = 14'h0000;
    localparam logic [INSTR_W-1:0] MSK_CALL_JUMP  = 14'h3800;
    localparam logic [INSTR_W-1:0] VAL_CALL       = 14'h2000;
    localparam logic [INSTR_W-1:0] VAL_ABS_JUMP   = 14'h2800;
    localparam logic [INSTR_W-1:0] MSK_FULL       = 14'h3fff;
    localparam logic [INSTR_W-1:0] VAL_RETURN     = 14'h0008;
    localparam logic [INSTR_W-1:0] VAL_INT_EXIT   = 14'h0009;
    localparam logic [INSTR_W-1:0] VAL_SUB_COMP   = 14'h000a;
    localparam logic [INSTR_W-1:0] VAL_ACC_JUMP   = 14'h000b;
    localparam logic [INSTR_W-1:0] MSK_BYTE_OP    = 14'h3f00;
    localparam logic [INSTR_W-1:0] VAL_EXIT_LIT   = 14'h3400;
    localparam logic [INSTR_W-1:0] VAL_DEC_SKIP   = 14'h0b00;
    localparam logic [INSTR_W-1:0] VAL_INC_SKIP   = 14'h0f00;
    localparam logic [INSTR_W-1:0] VAL_PTR_OFFSET = 14'h3f00;
    localparam logic [INSTR_W-1:0] MSK_REL_JUMP   = 14'h3e00;
    localparam logic [INSTR_W-1:0] VAL_REL_JUMP   = 14'h3200;
    localparam logic [INSTR_W-1:0] MSK_BIT_SKIP   = 14'h3c00;
    localparam logic [INSTR_W-1:0] VAL_SKIP_CLR   = 14'h1800;
    localparam logic [INSTR_W-1:0] VAL_SKIP_SET   = 14'h1c00;
    localparam logic [INSTR_W-1:0] MSK_PTR_MODE   = 14'h3ff0;
    localparam logic [INSTR_W-1:0] VAL_PTR_MODE   = 14'h0010;

    typedef enum logic [1:0] {
        CAT_BYTE    = 2'b00,
        CAT_BIT     = 2'b01,
        CAT_LITERAL = 2'b10
    } category_t;

    typedef enum logic [1:0] {
        MODE_PRE_INC  = 2'b00,
        MODE_PRE_DEC  = 2'b01,
        MODE_POST_INC = 2'b10,
        MODE_POST_DEC = 2'b11
    } ptr_mode_t;

    typedef enum logic [1:0] {
        ST_FILL  = 2'b00,
        ST_RUN   = 2'b01,
        ST_STALL = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic [FILE_ADDR_W-1:0] file_addr;
        logic [BIT_POS_W-1:0]   bit_pos;
        logic                   dest_file;
        logic                   ptr_num;
        ptr_mode_t              ptr_mode;
        logic [LITERAL_W-1:0]   literal;
    } fields_t;

    typedef struct packed {
        category_t              category;
        logic                   two_cycle;
        logic                   indirect;
        logic                   ptr_sel;
        logic                   file_op;
    } class_t;

    typedef struct packed {
        seq_state_t             state;
        logic [CYCLE_CNT_W-1:0] remain;
        logic                   issue;
        logic                   nop_cycle;
        logic                   flush;
        logic                   rmw_read;
        logic                   rmw_write;
        logic [CYCLE_CNT_W-1:0] cycles;
        category_t              category;
        fields_t                fields;
    } core_state_t;

    localparam fields_t FIELDS_RESET = '{
        file_addr: 7'h00, bit_pos: 3'h0, dest_file: DEST_DEFAULT,
        ptr_num: 1'b0, ptr_mode: MODE_PRE_INC, literal: 8'h00};

    localparam core_state_t STATE_RESET = '{
        state: ST_FILL, remain: 2'h0, issue: 1'b0, nop_cycle: 1'b0,
        flush: 1'b0, rmw_read: 1'b0, rmw_write: 1'b0, cycles: 2'h0,
        category: CAT_BYTE, fields: FIELDS_RESET};

endpackage : itd_pkg

/* File: rtl/instr_phase_div.sv */
// Divides the oscillator clock into the four phases of one instruction cycle.
// Assumes i_clk_sys is the oscillator clock and i_ce freezes all state.
`timescale 1ns/1ps
`default_nettype none
module instr_phase_div #(
    parameter int unsigned PHASES = itd_pkg::OSC_PER_INSTR
) (
    // Clock and reset
    input  wire logic       i_clk_sys,
    input  wire logic       i_nrst,
    input  wire logic       i_ce,
    // Phase
    output var  logic [1:0] o_phase,
    output var  logic       o_cycle_end
);

    localparam logic [1:0] PHASE_LAST = 2'(PHASES - 1);

    logic [1:0] phase_q;
    logic [1:0] phase_d;

    always_comb begin
        if (phase_q == PHASE_LAST) begin
            phase_d = itd_pkg::PHASE_RESET;
        end else begin
            phase_d = phase_q + 2'h1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            phase_q <= itd_pkg::PHASE_RESET;
        end else if (i_ce) begin
            phase_q <= phase_d;
        end
    end

    assign o_phase     = phase_q;
    assign o_cycle_end = i_ce && (phase_q == PHASE_LAST);

endmodule : instr_phase_div
`default_nettype wire

/* File: rtl/operand_extract.sv */
// Pulls the operand fields out of one instruction word.
// Assumes a stable word; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module operand_extract (
    // Word in
    input  wire logic [itd_pkg::INSTR_W-1:0] i_word,
    input  wire logic                        i_is_byte,
    input  wire logic                        i_ptr_mm_form,
    // Fields out
    output var  itd_pkg::fields_t            o_fields
);

    always_comb begin
        o_fields.file_addr = i_word[itd_pkg::FILE_LSB +: itd_pkg::FILE_ADDR_W];
        o_fields.bit_pos   = i_word[itd_pkg::BIT_POS_LSB +: itd_pkg::BIT_POS_W];
        // Only byte ops carry a destination bit; the rest write back to file
        o_fields.dest_file = i_is_byte ? i_word[itd_pkg::DEST_POS]
                                       : itd_pkg::DEST_DEFAULT;
        o_fields.ptr_num   = i_ptr_mm_form ? i_word[itd_pkg::PTR_MM_POS]
                                           : i_word[itd_pkg::PTR_K_POS];
        o_fields.ptr_mode  = itd_pkg::ptr_mode_t'(i_word[itd_pkg::MODE_LSB +: 2]);
        o_fields.literal   = i_word[itd_pkg::LITERAL_W-1:0];
    end

endmodule : operand_extract
`default_nettype wire

/* File: rtl/instr_timing_decode.sv */
// Instruction decoder and cycle timer of a small 8-bit core.
// Assumes program memory presents the fetched word on i_instr by the end
// of each instruction cycle, on the same clock.
//
// Notes on behaviour
// - Every instruction is one 14-bit word
// - Sort opcodes into byte, bit, literal/control
// - Ordinary instructions take one instruction cycle
// - Both subroutine entries take two cycles
// - All three returns take two cycles
// - Jumps and skip instructions take two cycles
// - Indirect access to program memory adds cycle
// - One instruction cycle is four oscillator clocks
// - File-register instructions always read then write
// - Destination bit: 0 accumulator, 1 file; default 1
// - File address spans 0x00 to 0x7F
// - Bit field picks one of eight bits
// - Pointer field picks pointer 0 or 1
// - Two-bit field picks pointer update mode
// - Don't-care bits never change the decode
`timescale 1ns/1ps
`default_nettype none
module instr_timing_decode #(
    parameter int unsigned OSC_PER_CYCLE = itd_pkg::OSC_PER_INSTR
) (
    // Clock and reset
    input  wire logic                              i_clk_sys,
    input  wire logic                              i_nrst,
    input  wire logic                              i_ce,
    // Fetched word and pointer state
    input  wire logic [itd_pkg::INSTR_W-1:0]       i_instr,
    input  wire logic [itd_pkg::PTR_COUNT-1:0]     i_ptr_in_prog,
    // Cycle timing
    output logic      [1:0]                        o_phase,
    output logic                                   o_cycle_end,
    // Decoded instruction
    output logic                                   o_issue,
    output itd_pkg::category_t                     o_category,
    output itd_pkg::fields_t                       o_fields,
    output logic      [itd_pkg::CYCLE_CNT_W-1:0]   o_cycles,
    // Execution control
    output logic                                   o_rmw_read,
    output logic                                   o_rmw_write,
    output logic                                   o_nop_cycle,
    output logic                                   o_flush
);

    // Returns true where the word matches value under mask; masks leave
    // out the don't-care positions so either level is accepted
    function automatic logic op_match(
        input logic [itd_pkg::INSTR_W-1:0] word,
        input logic [itd_pkg::INSTR_W-1:0] mask,
        input logic [itd_pkg::INSTR_W-1:0] value
    );
        op_match = ((word & mask) == value);
    endfunction : op_match

    function automatic itd_pkg::class_t classify(
        input logic [itd_pkg::INSTR_W-1:0] word
    );
        itd_pkg::class_t c;
        logic            sub_entry;
        logic            sub_exit;
        logic            branch;
        logic            port_hit;
        logic            ptr_mm;
        logic            ptr_k;
        c         = '0;
        sub_entry = op_match(word, itd_pkg::MSK_CALL_JUMP, itd_pkg::VAL_CALL)
                 || op_match(word, itd_pkg::MSK_FULL, itd_pkg::VAL_SUB_COMP);
        sub_exit  = op_match(word, itd_pkg::MSK_FULL, itd_pkg::VAL_RETURN)
                 || op_match(word, itd_pkg::MSK_FULL, itd_pkg::VAL_INT_EXIT)
                 || op_match(word, itd_pkg::MSK_BYTE_OP, itd_pkg::VAL_EXIT_LIT);
        branch    = op_match(word, itd_pkg::MSK_CALL_JUMP, itd_pkg::VAL_ABS_JUMP)
                 || op_match(word, itd_pkg::MSK_REL_JUMP, itd_pkg::VAL_REL_JUMP)
                 || op_match(word, itd_pkg::MSK_FULL, itd_pkg::VAL_ACC_JUMP)
                 || op_match(word, itd_pkg::MSK_BIT_SKIP, itd_pkg::VAL_SKIP_SET)
                 || op_match(word, itd_pkg::MSK_BIT_SKIP, itd_pkg::VAL_SKIP_CLR)
                 || op_match(word, itd_pkg::MSK_BYTE_OP, itd_pkg::VAL_DEC_SKIP)
                 || op_match(word, itd_pkg::MSK_BYTE_OP, itd_pkg::VAL_INC_SKIP);
        ptr_mm    = op_match(word, itd_pkg::MSK_PTR_MODE, itd_pkg::VAL_PTR_MODE);
        ptr_k     = op_match(word, itd_pkg::MSK_BYTE_OP, itd_pkg::VAL_PTR_OFFSET);
        port_hit  = ((word[itd_pkg::FILE_ADDR_W-1:0] & itd_pkg::ACCESS_PORT_MASK)
                     == itd_pkg::ACCESS_PORT_BASE);

        // Low control block sits inside the byte space and is split off first
        if (op_match(word, itd_pkg::MSK_CTRL_LOW, itd_pkg::VAL_CTRL_LOW)) begin
            c.category = itd_pkg::CAT_LITERAL;
        end else if (op_match(word, itd_pkg::MSK_TOP2, itd_pkg::VAL_BYTE)) begin
            c.category = itd_pkg::CAT_BYTE;
        end else if (op_match(word, itd_pkg::MSK_TOP2, itd_pkg::VAL_BIT)) begin
            c.category = itd_pkg::CAT_BIT;
        end else begin
            c.category = itd_pkg::CAT_LITERAL;
        end

        c.file_op   = (c.category != itd_pkg::CAT_LITERAL);
        c.two_cycle = sub_entry || sub_exit || branch;
        if (c.file_op) begin
            c.indirect = port_hit;
            c.ptr_sel  = word[0];
        end else if (ptr_mm) begin
            c.indirect = 1'b1;
            c.ptr_sel  = word[itd_pkg::PTR_MM_POS];
        end else if (ptr_k) begin
            c.indirect = 1'b1;
            c.ptr_sel  = word[itd_pkg::PTR_K_POS];
        end else begin
            c.indirect = 1'b0;
            c.ptr_sel  = 1'b0;
        end
        classify = c;
    endfunction : classify

    // Phase generator
    logic [1:0] phase;
    logic       cycle_end;

    instr_phase_div #(
        .PHASES      (OSC_PER_CYCLE)
    ) u_phase (
        .i_clk_sys   (i_clk_sys),
        .i_nrst      (i_nrst),
        .i_ce        (i_ce),
        .o_phase     (phase),
        .o_cycle_end (cycle_end)
    );

    // Word classification and operand fields
    itd_pkg::class_t  cls;
    itd_pkg::fields_t fields;
    logic             is_byte;
    logic             ptr_mm_form;
    logic             prog_hit;
    logic [itd_pkg::CYCLE_CNT_W-1:0] total_cycles;

    always_comb begin
        cls         = classify(i_instr);
        is_byte     = (cls.category == itd_pkg::CAT_BYTE);
        ptr_mm_form = op_match(i_instr, itd_pkg::MSK_PTR_MODE, itd_pkg::VAL_PTR_MODE);
        prog_hit    = cls.indirect && i_ptr_in_prog[cls.ptr_sel];
        total_cycles = itd_pkg::CYCLES_BASE;
        if (cls.two_cycle) begin
            total_cycles = total_cycles + itd_pkg::CYCLES_ADDED;
        end
        if (prog_hit) begin
            total_cycles = total_cycles + itd_pkg::CYCLES_ADDED;
        end
    end

    operand_extract u_fields (
        .i_word        (i_instr),
        .i_is_byte     (is_byte),
        .i_ptr_mm_form (ptr_mm_form),
        .o_fields      (fields)
    );

    // Sequencer state
    itd_pkg::core_state_t s_q;
    itd_pkg::core_state_t s_d;
    logic                 cycle_end_q;
    logic [1:0]           phase_q;

    always_comb begin
        s_d           = s_q;
        s_d.issue     = 1'b0;
        s_d.nop_cycle = 1'b0;
        s_d.flush     = 1'b0;
        s_d.rmw_read  = 1'b0;
        s_d.rmw_write = 1'b0;
        if (cycle_end) begin
            case (s_q.state)
                itd_pkg::ST_FILL: begin
                    // First word is still arriving; nothing to run yet
                    s_d.state = itd_pkg::ST_RUN;
                end
                itd_pkg::ST_RUN: begin
                    s_d.issue     = 1'b1;
                    s_d.category  = cls.category;
                    s_d.fields    = fields;
                    s_d.cycles    = total_cycles;
                    s_d.rmw_read  = cls.file_op;
                    s_d.rmw_write = cls.file_op;
                    if (total_cycles > itd_pkg::CYCLES_BASE) begin
                        s_d.state  = itd_pkg::ST_STALL;
                        s_d.remain = total_cycles - itd_pkg::CYCLES_BASE;
                    end
                end
                itd_pkg::ST_STALL: begin
                    // Word fetched behind a taken change of flow is thrown away
                    s_d.nop_cycle = 1'b1;
                    s_d.flush     = 1'b1;
                    s_d.remain    = s_q.remain - 2'h1;
                    if (s_q.remain == 2'h1) begin
                        // Target already fetched; a fill here would add a cycle
                        s_d.state = itd_pkg::ST_RUN;
                    end
                end
                default: begin
                    s_d.state = itd_pkg::ST_FILL;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            s_q         <= itd_pkg::STATE_RESET;
            cycle_end_q <= 1'b0;
            phase_q     <= itd_pkg::PHASE_RESET;
        end else if (i_ce) begin
            s_q         <= s_d;
            cycle_end_q <= cycle_end;
            phase_q     <= phase;
        end
    end

    // Outputs straight from flip-flops
    assign o_phase     = phase_q;
    assign o_cycle_end = cycle_end_q;
    assign o_issue     = s_q.issue;
    assign o_category  = s_q.category;
    assign o_fields    = s_q.fields;
    assign o_cycles    = s_q.cycles;
    assign o_rmw_read  = s_q.rmw_read;
    assign o_rmw_write = s_q.rmw_write;
    assign o_nop_cycle = s_q.nop_cycle;
    assign o_flush     = s_q.flush;

endmodule : instr_timing_decode
`default_nettype wire

/* File: verification/instr_timing_decode_asserts.sv */
// Port-level timing checks of the decoder.
// Assumes one clock domain; bound into instr_timing_decode.
`timescale 1ns/1ps
`default_nettype none
module instr_timing_decode_asserts #(
    parameter int unsigned OSC_PER_CYCLE = 4
) (
    // Clock, reset, inputs
    input wire logic                i_clk_sys,
    input wire logic                i_nrst,
    input wire logic                i_ce,
    input wire logic [13:0]         i_instr,
    input wire logic [1:0]          i_ptr_in_prog,
    // Outputs watched
    input wire logic [1:0]          o_phase,
    input wire logic                o_cycle_end,
    input wire logic                o_issue,
    input wire itd_pkg::category_t  o_category,
    input wire itd_pkg::fields_t    o_fields,
    input wire logic [1:0]          o_cycles,
    input wire logic                o_rmw_read,
    input wire logic                o_rmw_write,
    input wire logic                o_nop_cycle,
    input wire logic                o_flush
);
    // Settling count: phase outputs lag reset release
    logic [1:0] live_q;
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            live_q <= 2'h0;
        end else if (live_q != 2'h3) begin
            live_q <= live_q + 2'h1;
        end
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    property p_phase_step;
        live_q == 2'h3 && $past(i_ce) && $past(i_ce, 2) |-> o_phase == $past(o_phase) + 2'h1;
    endproperty
    a_phase_step: assert property (p_phase_step) else $error("phase did not step");
    property p_ce_freeze;
        live_q == 2'h3 && !i_ce |=> $stable(o_phase) && $stable(o_issue) && $stable(o_fields);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while disabled");
    property p_end_phase;
        o_cycle_end |-> o_phase == 2'h3;
    endproperty
    a_end_phase: assert property (p_end_phase) else $error("cycle end off phase 3");
    property p_issue_end;
        o_issue |-> o_cycle_end && !o_flush && o_cycles != 2'h0;
    endproperty
    a_issue_end: assert property (p_issue_end) else $error("issue off cycle end");
    property p_nop_flush;
        o_flush || o_nop_cycle |-> o_flush && o_nop_cycle && o_cycle_end;
    endproperty
    a_nop_flush: assert property (p_nop_flush) else $error("no-op and flush apart");
    property p_rmw;
        o_issue && o_category != itd_pkg::CAT_LITERAL |-> o_rmw_read && o_rmw_write;
    endproperty
    a_rmw: assert property (p_rmw) else $error("file op without read and write");
    property p_rmw_only;
        o_rmw_read || o_rmw_write |-> o_issue && o_category != itd_pkg::CAT_LITERAL;
    endproperty
    a_rmw_only: assert property (p_rmw_only) else $error("stray file access");
    property p_dest;
        o_issue && o_category != itd_pkg::CAT_BYTE |-> o_fields.dest_file;
    endproperty
    a_dest: assert property (p_dest) else $error("destination not default");
    property p_one_cyc;
        o_issue && o_cycles == 2'h1 && i_ce ##1 i_ce [*3] |=> o_issue;
    endproperty
    a_one_cyc: assert property (p_one_cyc) else $error("one-cycle op not followed");
    property p_two_cyc;
        o_issue && o_cycles == 2'h2 && i_ce ##1 i_ce [*7] |=> o_issue && $past(o_flush, 4);
    endproperty
    a_two_cyc: assert property (p_two_cyc) else $error("two-cycle op mistimed");
endmodule : instr_timing_decode_asserts

bind instr_timing_decode instr_timing_decode_asserts #(.OSC_PER_CYCLE(OSC_PER_CYCLE)) u_chk (
    .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(i_ce), .i_instr(i_instr),
    .i_ptr_in_prog(i_ptr_in_prog), .o_phase(o_phase), .o_cycle_end(o_cycle_end),
    .o_issue(o_issue), .o_category(o_category), .o_fields(o_fields), .o_cycles(o_cycles),
    .o_rmw_read(o_rmw_read), .o_rmw_write(o_rmw_write), .o_nop_cycle(o_nop_cycle),
    .o_flush(o_flush));
`default_nettype wire

/* File: verification/prog_mem_model.sv */
// Program memory model: hands out queued words, one per fetch.
// Assumes the core's registered phase lags its internal phase by one.
`timescale 1ns/1ps
`default_nettype none
module prog_mem_model (
    // Clock and reset
    input  wire logic        i_clk_sys,
    input  wire logic        i_nrst,
    input  wire logic        i_ce,
    input  wire logic [1:0]  i_phase,
    // Word out, pointer state travels with it
    output logic      [13:0] o_word,
    output logic      [1:0]  o_ptr
);
    logic [15:0] q[$];
    logic        take;
    initial begin
        o_word = 14'h0000;
        o_ptr = 2'h0;
        take = 1'b0;
    end
    // Capture edge is the enabled edge seen with registered phase 2
    always @(posedge i_clk_sys) begin
        take <= i_nrst && i_ce && (i_phase == 2'h2);
    end
    always @(negedge i_clk_sys) begin
        #1;
        if (take && q.size() > 0) void'(q.pop_front());
        // Empty memory toggles, so no stale word passes for a fetch
        if (q.size() > 0) {o_ptr, o_word} = q[0];
        else {o_ptr, o_word} = ~{o_ptr, o_word};
    end
endmodule : prog_mem_model
`default_nettype wire

/* File: verification/core_instruction_timing_decode_test.sv */
// Self-checking bench of the instruction decoder and cycle timer.
// Assumes the bench checker binds itself; memory model supplies words.
`timescale 1ns/1ps
`default_nettype none
module core_instruction_timing_decode_test;
    logic clk_sys, nrst, ce, ce_last, cyc_end, issue, rmw_rd, rmw_wr, nop_cyc, flush;
    logic [13:0] instr;
    logic [1:0] ptr_prog, phase, cycles;
    itd_pkg::category_t cat;
    itd_pkg::fields_t fld;
    int mismatches, n_tests, exp_gap, exp_fl, ce_hold;
    logic [15:0] exp_q[$];
    localparam logic [13:0] TWO [12] = '{14'h2123, 14'h000a, 14'h0008, 14'h0009, 14'h3455,
        14'h2a34, 14'h3201, 14'h1805, 14'h1c85, 14'h0b25, 14'h0fa5, 14'h000b};

    instr_timing_decode #(.OSC_PER_CYCLE(4)) dut (.i_clk_sys(clk_sys), .i_nrst(nrst),
        .i_ce(ce), .i_instr(instr), .i_ptr_in_prog(ptr_prog), .o_phase(phase),
        .o_cycle_end(cyc_end), .o_issue(issue), .o_category(cat), .o_fields(fld),
        .o_cycles(cycles), .o_rmw_read(rmw_rd), .o_rmw_write(rmw_wr),
        .o_nop_cycle(nop_cyc), .o_flush(flush));
    prog_mem_model mem (.i_clk_sys(clk_sys), .i_nrst(nrst), .i_ce(ce), .i_phase(phase),
        .o_word(instr), .o_ptr(ptr_prog));

    always @(posedge clk_sys) begin
        ce_last <= ce;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test

    // Word plus one discarded fetch per extra cycle
    task automatic load(input logic [13:0] w, input logic [1:0] p, input int c);
        mem.q.push_back({p, w});
        exp_q.push_back({c[1:0], w});
        repeat (c - 1) mem.q.push_back({2'h3, 14'h2fff});
    endtask : load

    task automatic do_reset(input int hold);
        nrst = 1'b0;
        exp_q.delete();
        mem.q.delete();
        mem.q.push_back({2'h3, 14'h2fff});
        repeat (hold) @(negedge clk_sys);
        check({issue, flush, rmw_rd, cyc_end, fld.dest_file}, 5'h01, "reset outputs");
        exp_gap = 8;
        exp_fl = 0;
        nrst = 1'b1;
    endtask : do_reset

    // Gap counts enabled edges only; a held-off clock enable must not count
    task automatic wait_issue(output int gap, output int fl);
        int n;
        gap = 0;
        fl = 0;
        for (n = 0; n < 64; n++) begin
            @(negedge clk_sys);
            gap += int'(ce_last);
            fl += int'(ce_last && flush);
            ce = (ce_hold == 0);
            if (ce_hold > 0) ce_hold--;
            if (ce_last && issue) return;
        end
        mismatches++;
        $display("mismatch at %0t: no issue", $time);
        end_of_test();
    endtask : wait_issue

    task automatic run_checks(input string name);
        int gap, fl;
        logic [15:0] e;
        logic [13:0] w;
        itd_pkg::category_t c;
        while (exp_q.size() > 0) begin
            e = exp_q.pop_front();
            w = e[13:0];
            c = w[13] ? itd_pkg::CAT_LITERAL : w[12] ? itd_pkg::CAT_BIT :
                (w[11:7] == 5'h00) ? itd_pkg::CAT_LITERAL : itd_pkg::CAT_BYTE;
            wait_issue(gap, fl);
            check(gap, exp_gap, "issue spacing");
            check(fl, exp_fl, "flush count");
            check(cat, c, "category");
            check(cycles, e[15:14], "cycles");
            check({rmw_rd, rmw_wr}, {2{c != itd_pkg::CAT_LITERAL}}, "rmw");
            check(fld.dest_file, (c == itd_pkg::CAT_BYTE) ? w[7] : 1'b1, "dest");
            if (c != itd_pkg::CAT_LITERAL) check(fld.file_addr, w[6:0], "file");
            if (c == itd_pkg::CAT_BIT) check(fld.bit_pos, w[9:7], "bit");
            if (w[13:4] == 10'h001) check({fld.ptr_num, fld.ptr_mode}, w[2:0], "ptr");
            if (w[13:8] == 6'h3f) check(fld.ptr_num, w[6], "ptr num");
            if (w[13:8] == 6'h34 || w[13:8] == 6'h3e) check(fld.literal, w[7:0], "lit");
            exp_gap = 4 * int'(e[15:14]);
            exp_fl = int'(e[15:14]) - 1;
        end
        $display("%s done", name);
    endtask : run_checks

    task automatic t_categories();
        load(14'h07ff, 2'h0, 1);
        load(14'h077f, 2'h0, 1);
        load(14'h13ff, 2'h0, 1);
        load(14'h3eaa, 2'h0, 1);
        load(14'h0780, 2'h2, 1);
        run_checks("categories");
    endtask : t_categories

    task automatic t_two_cycle();
        foreach (TWO[i]) load(TWO[i], 2'h0, 2);
        run_checks("two cycle");
    endtask : t_two_cycle

    task automatic t_indirect();
        load(14'h0781, 2'h2, 2);
        load(14'h0781, 2'h1, 1);
        for (int n = 0; n < 8; n++) load({11'h002, n[2:0]}, 2'h1, (n < 4) ? 2 : 1);
        load(14'h3f7f, 2'h2, 2);
        load(14'h3f3f, 2'h2, 1);
        load(14'h0b80, 2'h1, 3);
        run_checks("indirect");
    endtask : t_indirect

    task automatic t_ce_stall();
        load(14'h07ff, 2'h0, 1);
        load(14'h2a34, 2'h0, 2);
        load(14'h13ff, 2'h0, 1);
        ce_hold = 6;
        run_checks("clock enable");
    endtask : t_ce_stall

    task automatic t_reset();
        load(14'h2a34, 2'h0, 2);
        run_checks("before reset");
        repeat (2) @(negedge clk_sys);
        do_reset(2);
        load(14'h3e5a, 2'h0, 1);
        load(14'h0b80, 2'h1, 3);
        run_checks("after reset");
    endtask : t_reset

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    initial begin
        nrst = 1'b0;
        ce = 1'b1;
        ce_last = 1'b0;
        mismatches = 0;
        n_tests = 0;
        ce_hold = 0;
        do_reset(8);
        t_categories();
        t_two_cycle();
        t_indirect();
        t_ce_stall();
        t_reset();
        end_of_test();
    end
endmodule : core_instruction_timing_decode_test
`default_nettype wire
